/* File: pkg/rtpwm_pkg.sv */
package rtpwm_pkg;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THR1 = 8'h04;
    localparam logic [7:0] ADDR_THR2 = 8'h08;
    localparam logic [7:0] ADDR_HYSTERESIS_WIDTH = 8'h0C;
    localparam logic [7:0] ADDR_TON = 8'h10;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h14;
    localparam logic [7:0] ADDR_LIMLO = 8'h18;
    localparam logic [7:0] ADDR_LIMHI = 8'h1C;
    localparam logic [7:0] ADDR_PERIOD = 8'h20;
    localparam logic [7:0] ADDR_MINHI = 8'h24;
    localparam logic [7:0] ADDR_MINLO = 8'h28;
    localparam logic [7:0] ADDR_SRCREG = 8'h2C;
    localparam logic [7:0] ADDR_STATUS = 8'h30;

    // ctrl field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_LSB = 3;
    localparam int CTRL_ALM_LSB = 5;
    localparam int CTRL_UNIT_LSB = 7;
    localparam int CTRL_PEAK_BIT = 9;
    localparam int CTRL_VALID_BIT = 10;
    localparam int CTRL_ALDUTY_LSB = 16;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] VAL_RESET = 16'h0000;

    typedef enum logic [2:0] {
        MODE_OUTPUT_DISABLED_SETTING,
        MODE_ON,
        MODE_OFF,
        MODE_IN,
        MODE_OUT,
        MODE_PULSE_WIDTH_OUTPUT_SETTING
    } rtpwm_mode_e;

    typedef enum logic [1:0] {
        SRC_MEASUREMENT_INPUT_SOURCE,
        SRC_FIELDBUS,
        SRC_HEATING_LOOP_SOURCE,
        SRC_COOLING_LOOP_SOURCE
    } rtpwm_src_e;

    typedef enum logic [1:0] {
        ALM_FORCE_ON,
        ALM_FORCE_OFF,
        ALM_HOLD
    } rtpwm_alm_e;

    // delay time bases
    localparam int CLK_MHZ = 100;
    localparam int UNIT_MS_US = 1000;
    localparam int UNIT_S_US = 1000000;
    localparam int UNIT_MIN_US = 60000000;
    localparam int UNIT_MS_CYC = UNIT_MS_US * CLK_MHZ;
    localparam int UNIT_S_CYC = UNIT_S_US * CLK_MHZ;
    // minute base does not fit a 32-bit int
    localparam longint UNIT_MIN_CYC = longint'(UNIT_MIN_US) * CLK_MHZ;
    // pulse period, min high, min low are in ms ticks
    localparam int PWM_TICK_MS = 1;

    typedef struct packed {
        logic signed [15:0] measurement;
        logic signed [15:0] peak;
        logic signed [15:0] heat_loop;
        logic signed [15:0] cool_loop;
    } rtpwm_src_s;

endpackage

/* File: src/rtpwm_output.sv */
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module rtpwm_output
    import rtpwm_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire rtpwm_src_s src_in, // candidate source values
    input wire logic alarm_in, // critical condition
    output logic relay_out, // relay drive
    output logic led_out, // indicator led
    output logic open_collector_output // pulse or switching output
);

    function automatic logic signed [15:0] smin(input logic signed [15:0] a, input logic signed [15:0] b);
        smin = (a < b) ? a : b;
    endfunction

    function automatic logic signed [15:0] smax(input logic signed [15:0] a, input logic signed [15:0] b);
        smax = (a < b) ? b : a;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl;
    logic signed [15:0] primary_threshold;
    logic signed [15:0] secondary_threshold;
    logic signed [15:0] hysteresis_width;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    logic signed [15:0] source_low_limit;
    logic signed [15:0] source_high_limit;
    logic [15:0] pulse_period;
    logic [15:0] min_high_time;
    logic [15:0] min_low_time;
    logic signed [15:0] fieldbus_value;
    logic out_state;

    logic acc;
    assign acc = psel & penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            primary_threshold <= VAL_RESET;
            secondary_threshold <= VAL_RESET;
            hysteresis_width <= VAL_RESET;
            on_delay <= VAL_RESET;
            off_delay <= VAL_RESET;
            source_low_limit <= VAL_RESET;
            source_high_limit <= VAL_RESET;
            pulse_period <= VAL_RESET;
            min_high_time <= VAL_RESET;
            min_low_time <= VAL_RESET;
            fieldbus_value <= VAL_RESET;
        end else if (acc && pwrite) begin
            unique case (paddr)
                ADDR_CTRL: ctrl <= pwdata;
                ADDR_THR1: primary_threshold <= pwdata[15:0];
                ADDR_THR2: secondary_threshold <= pwdata[15:0];
                ADDR_HYSTERESIS_WIDTH: hysteresis_width <= pwdata[15:0];
                ADDR_TON: on_delay <= pwdata[15:0];
                ADDR_OFF_DELAY: off_delay <= pwdata[15:0];
                ADDR_LIMLO: source_low_limit <= pwdata[15:0];
                ADDR_LIMHI: source_high_limit <= pwdata[15:0];
                ADDR_PERIOD: pulse_period <= pwdata[15:0];
                ADDR_MINHI: min_high_time <= pwdata[15:0];
                ADDR_MINLO: min_low_time <= pwdata[15:0];
                ADDR_SRCREG: fieldbus_value <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    logic dec_ok;
    logic [31:0] rd_mux;
    always_comb begin
        dec_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL: rd_mux = ctrl;
            ADDR_THR1: rd_mux = {16'h0000, primary_threshold};
            ADDR_THR2: rd_mux = {16'h0000, secondary_threshold};
            ADDR_HYSTERESIS_WIDTH: rd_mux = {16'h0000, hysteresis_width};
            ADDR_TON: rd_mux = {16'h0000, on_delay};
            ADDR_OFF_DELAY: rd_mux = {16'h0000, off_delay};
            ADDR_LIMLO: rd_mux = {16'h0000, source_low_limit};
            ADDR_LIMHI: rd_mux = {16'h0000, source_high_limit};
            ADDR_PERIOD: rd_mux = {16'h0000, pulse_period};
            ADDR_MINHI: rd_mux = {16'h0000, min_high_time};
            ADDR_MINLO: rd_mux = {16'h0000, min_low_time};
            ADDR_SRCREG: rd_mux = {16'h0000, fieldbus_value};
            ADDR_STATUS: rd_mux = {29'h0000_0000, open_collector_output, led_out, out_state};
            default: dec_ok = 1'b0;
        endcase
    end

    // zero wait state slave; unmapped address answers with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~dec_ok;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration decode
    rtpwm_mode_e mode;
    rtpwm_src_e src_sel;
    rtpwm_alm_e alm;
    logic [1:0] unit_sel;
    logic peak_sel;
    logic cfg_valid;
    logic [6:0] alarm_duty;
    assign mode = rtpwm_mode_e'(ctrl[CTRL_MODE_LSB +: 3]);
    assign src_sel = rtpwm_src_e'(ctrl[CTRL_SRC_LSB +: 2]);
    assign alm = rtpwm_alm_e'(ctrl[CTRL_ALM_LSB +: 2]);
    assign unit_sel = ctrl[CTRL_UNIT_LSB +: 2];
    assign peak_sel = ctrl[CTRL_PEAK_BIT];
    assign cfg_valid = ctrl[CTRL_VALID_BIT];
    assign alarm_duty = ctrl[CTRL_ALDUTY_LSB +: 7];

    // alarm pin comes from another domain
    logic alarm_s1;
    logic alarm_s2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_s1 <= 1'b0;
            alarm_s2 <= 1'b0;
        end else begin
            alarm_s1 <= alarm_in;
            alarm_s2 <= alarm_s1;
        end
    end

    logic signed [15:0] src_val;
    always_comb begin
        unique case (src_sel)
            SRC_MEASUREMENT_INPUT_SOURCE: src_val = peak_sel ? src_in.peak : src_in.measurement;
            SRC_FIELDBUS: src_val = fieldbus_value;
            SRC_HEATING_LOOP_SOURCE: src_val = src_in.heat_loop;
            SRC_COOLING_LOOP_SOURCE: src_val = src_in.cool_loop;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // threshold zones
    logic signed [16:0] lo_thr;
    logic signed [16:0] hi_thr;
    logic signed [16:0] sv;
    logic zone_a_enter;
    logic zone_b_enter;
    assign lo_thr = 17'(smin(primary_threshold, secondary_threshold));
    assign hi_thr = 17'(smax(primary_threshold, secondary_threshold));
    assign sv = 17'(src_val);
    always_comb begin
        if (mode == MODE_IN || mode == MODE_OUT) begin
            // band shrunk by hysteresis on both edges
            zone_a_enter = (sv > lo_thr + 17'(hysteresis_width)) && (sv < hi_thr - 17'(hysteresis_width));
            zone_b_enter = (sv < lo_thr - 17'(hysteresis_width)) || (sv > hi_thr + 17'(hysteresis_width));
        end else begin
            zone_a_enter = sv > 17'(primary_threshold) + 17'(hysteresis_width);
            zone_b_enter = sv < 17'(primary_threshold) - 17'(hysteresis_width);
        end
    end

    logic want_on;
    logic want_off;
    always_comb begin
        unique case (mode)
            MODE_ON, MODE_IN: begin
                want_on = zone_a_enter;
                want_off = zone_b_enter;
            end
            MODE_OFF, MODE_OUT: begin
                want_on = zone_b_enter;
                want_off = zone_a_enter;
            end
            default: begin
                want_on = 1'b0;
                want_off = 1'b0;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // qualification timers
    // 33 bits: the minute base needs them
    logic [32:0] unit_cyc;
    always_comb begin
        unique case (unit_sel)
            2'h0: unit_cyc = 33'(UNIT_MS_CYC);
            2'h1: unit_cyc = 33'(UNIT_S_CYC);
            default: unit_cyc = 33'(UNIT_MIN_CYC);
        endcase
    end

    logic [32:0] pre_cnt;
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic tick;
    // compare with >= so a shorter unit chosen mid count still ticks
    assign tick = (pre_cnt >= unit_cyc - 33'h0_0000_0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 33'h0_0000_0000;
        end else if (!cfg_valid || tick) begin
            pre_cnt <= 33'h0_0000_0000;
        end else begin
            pre_cnt <= pre_cnt + 33'h0_0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= 16'h0000;
            off_cnt <= 16'h0000;
        end else if (!cfg_valid) begin
            on_cnt <= 16'h0000;
            off_cnt <= 16'h0000;
        end else begin
            if (!want_on) begin
                on_cnt <= 16'h0000;
            end else if (tick && on_cnt != 16'hFFFF) begin
                on_cnt <= on_cnt + 16'h0001;
            end
            if (!want_off) begin
                off_cnt <= 16'h0000;
            end else if (tick && off_cnt != 16'hFFFF) begin
                off_cnt <= off_cnt + 16'h0001;
            end
        end
    end

    logic qual_on;
    logic qual_off;
    assign qual_on = want_on && (on_cnt >= on_delay);
    assign qual_off = want_off && (off_cnt >= off_delay);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_state <= 1'b0;
        end else if (!cfg_valid || mode == MODE_OUTPUT_DISABLED_SETTING) begin
            out_state <= 1'b0;
        end else if (alarm_s2) begin
            unique case (alm)
                ALM_FORCE_ON: out_state <= 1'b1;
                ALM_FORCE_OFF: out_state <= 1'b0;
                default: out_state <= out_state;
            endcase
        end else if (qual_on) begin
            out_state <= 1'b1;
        end else if (qual_off) begin
            out_state <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pulse mode
    localparam int MS_CYC = PWM_TICK_MS * UNIT_MS_CYC;
    logic [31:0] ms_cnt;
    logic ms_tick;
    logic [15:0] pos;
    logic [15:0] high_len;
    logic pulse_on;
    logic pwm_en;
    assign pwm_en = cfg_valid && (mode == MODE_PULSE_WIDTH_OUTPUT_SETTING);
    assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));

    logic [32:0] span;
    logic [32:0] offs;
    logic [48:0] prod;
    logic [15:0] lin_len;
    logic [15:0] duty_len;
    logic [17:0] min_sum;
    always_comb begin
        span = 33'(source_high_limit) - 33'(source_low_limit);
        offs = 33'(src_val) - 33'(source_low_limit);
        prod = 49'(offs[15:0]) * 49'(pulse_period);
        lin_len = (span[15:0] == 16'h0000) ? 16'h0000 : 16'(prod / 49'(span[15:0]));
        if (alarm_s2) begin
            duty_len = 16'((32'(alarm_duty) * 32'(pulse_period)) / 32'h0000_0064);
        end else if (src_val < source_low_limit) begin
            duty_len = 16'h0000;
        end else if (src_val > source_high_limit) begin
            duty_len = pulse_period;
        end else begin
            duty_len = lin_len;
        end
        min_sum = 18'(min_high_time) + 18'(min_low_time);
        if (min_sum > 18'(pulse_period)) begin
            high_len = 16'h0000;
        end else if (duty_len < min_high_time) begin
            high_len = min_high_time;
        end else if (duty_len > pulse_period - min_low_time) begin
            high_len = pulse_period - min_low_time;
        end else begin
            high_len = duty_len;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= 32'h0000_0000;
            pos <= 16'h0000;
        end else if (!pwm_en) begin
            ms_cnt <= 32'h0000_0000;
            pos <= 16'h0000;
        end else if (ms_tick) begin
            ms_cnt <= 32'h0000_0000;
            pos <= (pos + 16'h0001 >= pulse_period) ? 16'h0000 : pos + 16'h0001;
        end else begin
            ms_cnt <= ms_cnt + 32'h0000_0001;
        end
    end

    // high length latched at period start so each cycle stays whole
    logic [15:0] cur_high;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_high <= 16'h0000;
        end else if (!pwm_en || (ms_tick && pos + 16'h0001 >= pulse_period)) begin
            cur_high <= high_len;
        end
    end
    assign pulse_on = pwm_en && (pos < cur_high);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_out <= 1'b0;
            led_out <= 1'b0;
            open_collector_output <= 1'b0;
        end else begin
            relay_out <= out_state;
            led_out <= pwm_en ? pulse_on : out_state;
            open_collector_output <= pwm_en ? pulse_on : out_state;
        end
    end

endmodule

/* File: testbench/rtpwm_load.sv */
`timescale 1ns/1ns
////////////////////////////////////////
// far side load: counts contact closures of the relay
module rtpwm_load (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic relay_out, // relay coil drive
    output logic [7:0] relay_rises // contact closures seen
);
    logic relay_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_q <= 1'b0;
            relay_rises <= 8'h00;
        end else begin
            relay_q <= relay_out;
            if (relay_out && !relay_q) begin
                relay_rises <= relay_rises + 8'h01;
            end
        end
    end
endmodule

/* File: testbench/rtpwm_output_chk.sv */
`timescale 1ns/1ns
module rtpwm_output_chk
    import rtpwm_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire rtpwm_src_s src_in, // source values
    input wire logic alarm_in, // critical condition
    input wire logic relay_out, // relay drive
    input wire logic led_out, // indicator led
    input wire logic open_collector_output // switching output
);
    // shadow of the settings, rebuilt from completed bus writes
    logic [31:0] regs [0:15];
    logic [2:0] age;
    logic [2:0] mode;
    logic cfg_ok;
    logic zero_dly;
    logic signed [16:0] val, hi_b, lo_b;
    assign mode = regs[0][2:0];
    assign val = src_in.measurement;
    assign hi_b = $signed(regs[1][15:0]) + $signed(regs[3][15:0]);
    assign lo_b = $signed(regs[1][15:0]) - $signed(regs[3][15:0]);
    assign zero_dly = regs[4][15:0] == 16'h0000 && regs[5][15:0] == 16'h0000;
    assign cfg_ok = age == 3'h7 && regs[0][10] && regs[0][4:3] == 2'h0 && !regs[0][9] && zero_dly && !alarm_in;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 32'h0000_0000;
            end
            age <= 3'h7;
        end else if (psel && penable && pready && pwrite && !pslverr) begin
            regs[paddr[5:2]] <= pwdata;
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_reset_out;
        $rose(presetn) |-> !relay_out && !led_out && !open_collector_output;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("output on after reset");
    property p_invalid;
        age == 3'h7 && !regs[0][10] |-> !relay_out && !led_out && !open_collector_output;
    endproperty
    a_invalid: assert property (p_invalid) else $error("output on without valid setup");
    property p_disabled;
        age == 3'h7 && regs[0][10] && mode == MODE_OUTPUT_DISABLED_SETTING |-> !relay_out && !open_collector_output;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled output is on");
    property p_led_mirror;
        age == 3'h7 && mode != MODE_PULSE_WIDTH_OUTPUT_SETTING |-> led_out == relay_out;
    endproperty
    a_led_mirror: assert property (p_led_mirror) else $error("led differs from relay");
    property p_on_above;
        (cfg_ok && mode == MODE_ON && val > hi_b)[*6] |-> relay_out;
    endproperty
    a_on_above: assert property (p_on_above) else $error("relay off above upper border");
    property p_on_below;
        (cfg_ok && mode == MODE_ON && val < lo_b)[*6] |-> !relay_out;
    endproperty
    a_on_below: assert property (p_on_below) else $error("relay on below lower border");
    property p_off_above;
        (cfg_ok && mode == MODE_OFF && val > hi_b)[*6] |-> !relay_out;
    endproperty
    a_off_above: assert property (p_off_above) else $error("inverted relay on above border");
    property p_alarm_off;
        (age == 3'h7 && regs[0][10] && regs[0][6:5] == ALM_FORCE_OFF
            && mode != MODE_PULSE_WIDTH_OUTPUT_SETTING && alarm_in)[*6] |-> !relay_out;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("relay on in forced off alarm");
endmodule
bind rtpwm_output rtpwm_output_chk rtpwm_output_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
    .alarm_in(alarm_in), .relay_out(relay_out), .led_out(led_out), .open_collector_output(open_collector_output)
);

/* File: testbench/tb_rtpwm_output.sv */
`timescale 1ns/1ns
module tb_rtpwm_output;
    import rtpwm_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic sw;
        logic [15:0] v;
        logic q;
    } rtpwm_row_s;
    localparam rtpwm_row_s ROWS [18] = '{
        '{16'h0441, 1'b0, 16'h00C8, 1'b1}, '{16'h0441, 1'b0, 16'h0069, 1'b1}, '{16'h0441, 1'b0, 16'h0032, 1'b0},
        '{16'h0442, 1'b0, 16'h00C8, 1'b0}, '{16'h0442, 1'b0, 16'h0032, 1'b1}, '{16'h0443, 1'b1, 16'h00C8, 1'b1},
        '{16'h0443, 1'b1, 16'h0032, 1'b0}, '{16'h0444, 1'b1, 16'h0032, 1'b1}, '{16'h0444, 1'b1, 16'h00C8, 1'b0},
        '{16'h0444, 1'b1, 16'h0190, 1'b1}, '{16'h0440, 1'b1, 16'h0190, 1'b0}, '{16'h0449, 1'b0, 16'h00C8, 1'b1},
        '{16'h0441, 1'b0, 16'h0032, 1'b0}, '{16'h0451, 1'b0, 16'h00C8, 1'b1}, '{16'h0441, 1'b0, 16'h0032, 1'b0},
        '{16'h0459, 1'b0, 16'h00C8, 1'b1}, '{16'h0441, 1'b0, 16'h0032, 1'b0}, '{16'h0641, 1'b0, 16'h00C8, 1'b1}
    };
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm_in, relay_out, led_out, er, pq;
    logic open_collector_output;
    logic [7:0] paddr, relay_rises;
    logic [31:0] pwdata, prdata, rd;
    rtpwm_src_s src_in;
    int error_cnt, checked, ups;
    rtpwm_output rtpwm_output_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
        .alarm_in(alarm_in), .relay_out(relay_out), .led_out(led_out), .open_collector_output(open_collector_output)
    );
    rtpwm_load rtpwm_load_i (.pclk(pclk), .presetn(presetn), .relay_out(relay_out), .relay_rises(relay_rises));
    always #5 pclk = ~pclk;
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // request held until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check(1'b0, 1'b1);
            close_out();
        end
    endtask
    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // selected source carries v, every other source reads zero
    // source values change at the control write edge so no stray relay closure appears
    task automatic apply(input logic [15:0] c, input logic sw, input logic [15:0] v);
        apb_wr(ADDR_THR1, sw ? 32'h0000_012C : 32'h0000_0064);
        apb_wr(ADDR_THR2, sw ? 32'h0000_0064 : 32'h0000_012C);
        apb_wr(ADDR_SRCREG, {16'h0000, (c[4:3] == 2'h1) ? v : 16'h0000});
        apb_wr(ADDR_CTRL, {16'h0000, c});
        src_in <= '{(c[4:3] == 2'h0 && !c[9]) ? v : 16'h0000, c[9] ? v : 16'h0000,
            (c[4:3] == 2'h2) ? v : 16'h0000, (c[4:3] == 2'h3) ? v : 16'h0000};
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic set_alarm(input logic b);
        @(posedge pclk);
        alarm_in <= b;
    endtask
    ////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, alarm_in, pq} = 7'h00;
        {paddr, pwdata, src_in} = '0;
        {error_cnt, checked, ups} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 13; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0000_0000);
            check(rd, 32'h0000_0000);
            check(er, 1'b0);
        end
        apb_wr(ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
        check(relay_out, 1'b0);
        apb_wr(ADDR_HYSTERESIS_WIDTH, 32'h0000_000A);
        $display("test registers done");
        for (int i = 0; i < 18; i++) begin
            apply(ROWS[i].ctrl, ROWS[i].sw, ROWS[i].v);
            settle(14);
            check(relay_out, ROWS[i].q);
            check({led_out, open_collector_output}, {2{ROWS[i].q}});
            ups += (ROWS[i].q && !pq) ? 1 : 0;
            pq = ROWS[i].q;
        end
        check(relay_rises, 8'(ups));
        $display("test thresholds done");
        apply(16'h0421, 1'b0, 16'h00C8);
        set_alarm(1'b1);
        settle(8);
        check(relay_out, 1'b0);
        apply(16'h0401, 1'b0, 16'h0032);
        settle(8);
        check(relay_out, 1'b1);
        set_alarm(1'b0);
        apply(16'h0441, 1'b0, 16'h00C8);
        set_alarm(1'b1);
        apply(16'h0441, 1'b0, 16'h0032);
        settle(8);
        check(relay_out, 1'b1);
        set_alarm(1'b0);
        settle(8);
        check(relay_out, 1'b0);
        $display("test alarm done");
        apb_wr(ADDR_LIMLO, 32'h0000_0064);
        apb_wr(ADDR_LIMHI, 32'h0000_012C);
        apb_wr(ADDR_PERIOD, 32'h0000_000A);
        for (int k = 0; k < 4; k++) begin
            apb_wr(ADDR_MINHI, (k == 2) ? 32'h0000_0006 : 32'h0000_0000);
            apb_wr(ADDR_MINLO, (k == 2) ? 32'h0000_0006 : 32'h0000_0000);
            set_alarm(k == 3);
            // parked in disabled mode first so the period latch sees the new source and duty
            apply(16'h0400, 1'b0, (k == 0 || k == 3) ? 16'h0032 : 16'h0190);
            apply(16'h0445, 1'b0, (k == 0 || k == 3) ? 16'h0032 : 16'h0190);
            if (k == 3) begin
                apb_wr(ADDR_CTRL, 32'h0064_0440);
                apb_wr(ADDR_CTRL, 32'h0064_0445);
            end
            settle(14);
            check(open_collector_output, (k == 1 || k == 3));
        end
        set_alarm(1'b0);
        $display("test pulse done");
        // prescaler restarts from zero, so no delay tick can land in these few cycles
        apb_wr(ADDR_CTRL, 32'h0000_0000);
        apb_wr(ADDR_TON, 32'h0000_0001);
        apply(16'h0441, 1'b0, 16'h00C8);
        settle(14);
        check(relay_out, 1'b0);
        apply(16'h0441, 1'b0, 16'h0032);
        apply(16'h0441, 1'b0, 16'h00C8);
        settle(14);
        check(relay_out, 1'b0);
        apb_wr(ADDR_TON, 32'h0000_0000);
        settle(4);
        check(relay_out, 1'b1);
        $display("test delay done");
        @(posedge pclk);
        presetn <= 1'b0;
        settle(1);
        check({relay_out, led_out, open_collector_output}, 3'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        check(rd, CTRL_RESET);
        settle(4);
        check(relay_out, 1'b0);
        $display("test reset done");
        close_out();
    end
endmodule
